// ==== crp_top.sv ====
// Configuration rows, register preload and power-up reset of a small logic array.
// Assumes a 20 MHz clk, an Avalon-MM master for programming, and tester pins that are asynchronous.
//
// Overview of operation
// - Exactly 36 row addresses accepted for programming
// - Rows 0-31 hold 64-bit term data
// - Row 32 holds user signature word
// - Rows 33-59 reserved, refused for user data
// - Row 60 holds 82-bit architecture word
// - Row 61 security bit blocks array access
// - Security bit cleared only by bulk erase
// - Signature reads succeed regardless of security
// - Programming row 63 erases everything
// - Eight polarity bits set each output sense
// - Outer cells use registered-capability as selector
// - Elevated entry pin starts preload, io_oe left unchanged
// - One bit shifted per shift clock rise
// - Only registered macrocells join the chain
// - Chain fills from bottom cell upward
// - Registers forced low within 45 us
// - Registered pins show high after power-up
// - Architecture bits select mode and feedback

module crp_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM register slave
  input wire logic [crp_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Logic pins
  input wire logic [crp_pkg::NUM_IN-1:0] in_pin,
  input wire logic oe_n_pin,
  input wire logic [crp_pkg::NUM_CELLS-1:0] io_in,
  output logic [crp_pkg::NUM_CELLS-1:0] io_out,
  output logic [crp_pkg::NUM_CELLS-1:0] io_oe,
  // Preload test pins
  input wire logic preload_entry_pin,
  input wire logic preload_shift_clock,
  input wire logic sdin_pin,
  output logic sdout_out,
  output logic sdout_oe,
  // Status
  output logic por_done
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  localparam int unsigned SYNC_W = crp_pkg::NUM_IN + crp_pkg::NUM_CELLS + 4;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic [crp_pkg::NUM_IN-1:0] in_s;
  logic [crp_pkg::NUM_CELLS-1:0] io_s;
  logic oe_n_s;
  logic preload_s;
  logic preload_shift_clock_s;
  logic sdin_s;
  logic preload_shift_clock_prev_q;
  logic shift_edge;

  assign pins_raw = {in_pin, io_in, oe_n_pin, preload_entry_pin, preload_shift_clock, sdin_pin};

  crp_sync2 #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(pins_raw),
    .q(pins_s)
  );

  assign {in_s, io_s, oe_n_s, preload_s, preload_shift_clock_s, sdin_s} = pins_s;

  // Rising edge of the synchronised shift clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      preload_shift_clock_prev_q <= 1'b0;
    end else begin
      preload_shift_clock_prev_q <= preload_shift_clock_s;
    end
  end

  assign shift_edge = preload_shift_clock_s & ~preload_shift_clock_prev_q;

  // ----------------------------------------------------------------------
  // Power-up reset timer
  // ----------------------------------------------------------------------
  logic [crp_pkg::POR_CNT_W-1:0] por_cnt_q;
  logic por_done_q;

  // Registers stay cleared until the window closes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_cnt_q <= '0;
      por_done_q <= 1'b0;
    end else if (!por_done_q) begin
      if (por_cnt_q == crp_pkg::POR_LAST) begin
        por_done_q <= 1'b1;
      end else begin
        por_cnt_q <= por_cnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Nonvolatile rows
  // ----------------------------------------------------------------------
  logic [crp_pkg::TERM_BITS-1:0] array_q [crp_pkg::ARRAY_ROWS];
  logic [crp_pkg::SIG_BITS-1:0] sig_q;
  logic [crp_pkg::ARCH_BITS-1:0] arch_q;
  logic sec_q;

  // Register-side programming state
  logic [crp_pkg::ROW_W-1:0] row_q;
  logic [31:0] data0_q;
  logic [31:0] data1_q;
  logic [crp_pkg::ARCH_HI_W-1:0] data2_q;
  logic [31:0] data2_m;
  logic [31:0] rdat0_q;
  logic [31:0] rdat1_q;
  logic [crp_pkg::ARCH_HI_W-1:0] rdat2_q;
  logic err_q;

  logic take;
  logic wr;
  logic rd;
  logic prog_go;
  logic read_go;
  logic in_array;
  logic prog_ok;
  logic read_ok;

  // Bus handshake: request taken while waitrequest is high, a write lands at the edge it is low
  assign take = (avs_read | avs_write) & avs_waitrequest;
  assign wr = avs_write & ~avs_waitrequest;
  assign rd = take & avs_read;
  assign prog_go = wr && (avs_address == crp_pkg::OFS_CMD) && avs_byteenable[0] &&
                   avs_writedata[crp_pkg::CMD_PROG_BIT];
  assign read_go = wr && (avs_address == crp_pkg::OFS_CMD) && avs_byteenable[0] &&
                   avs_writedata[crp_pkg::CMD_READ_BIT] && !avs_writedata[crp_pkg::CMD_PROG_BIT];

  // Accepted rows: 0-31 when unsecured, 32, 60, 61, and 63 for programming only; reserved and 62 refused
  assign in_array = (row_q <= crp_pkg::ROW_ARRAY_LAST);
  assign prog_ok = (in_array & ~sec_q) | (row_q == crp_pkg::ROW_SIG) |
                   (row_q == crp_pkg::ROW_ARCH) | (row_q == crp_pkg::ROW_SEC) |
                   (row_q == crp_pkg::ROW_ERASE);
  assign read_ok = (in_array & ~sec_q) | (row_q == crp_pkg::ROW_SIG) |
                   (row_q == crp_pkg::ROW_ARCH) | (row_q == crp_pkg::ROW_SEC);

  function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  assign data2_m = be_merge({{(32 - crp_pkg::ARCH_HI_W){1'b0}}, data2_q}, avs_writedata, avs_byteenable);

  // Staging registers for row number and write data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      row_q <= '0;
      data0_q <= '0;
      data1_q <= '0;
      data2_q <= '0;
    end else if (wr) begin
      if (avs_address == crp_pkg::OFS_ROW && avs_byteenable[0]) begin
        row_q <= avs_writedata[crp_pkg::ROW_W-1:0];
      end
      if (avs_address == crp_pkg::OFS_DATA0) begin
        data0_q <= be_merge(data0_q, avs_writedata, avs_byteenable);
      end
      if (avs_address == crp_pkg::OFS_DATA1) begin
        data1_q <= be_merge(data1_q, avs_writedata, avs_byteenable);
      end
      if (avs_address == crp_pkg::OFS_DATA2) begin
        data2_q <= data2_m[crp_pkg::ARCH_HI_W-1:0];
      end
    end
  end

  // Row programming and bulk erase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int r = 0; r < crp_pkg::ARRAY_ROWS; r++) begin
        array_q[r] <= crp_pkg::ROW_ERASED;
      end
      sig_q <= crp_pkg::SIG_ERASED;
      arch_q <= crp_pkg::ARCH_ERASED;
      sec_q <= 1'b0;
    end else if (prog_go && prog_ok) begin
      if (row_q == crp_pkg::ROW_ERASE) begin
        for (int r = 0; r < crp_pkg::ARRAY_ROWS; r++) begin
          array_q[r] <= crp_pkg::ROW_ERASED;
        end
        sig_q <= crp_pkg::SIG_ERASED;
        arch_q <= crp_pkg::ARCH_ERASED;
        sec_q <= 1'b0;
      end else if (in_array) begin
        array_q[row_q[4:0]] <= {data1_q, data0_q};
      end else if (row_q == crp_pkg::ROW_SIG) begin
        sig_q <= {data1_q, data0_q};
      end else if (row_q == crp_pkg::ROW_ARCH) begin
        arch_q <= {data2_q, data1_q, data0_q};
      end else begin
        sec_q <= 1'b1;
      end
    end
  end

  // Verify reads into the readback registers; refused rows read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdat0_q <= '0;
      rdat1_q <= '0;
      rdat2_q <= '0;
    end else if (read_go) begin
      if (!read_ok) begin
        {rdat2_q, rdat1_q, rdat0_q} <= '0;
      end else if (in_array) begin
        {rdat2_q, rdat1_q, rdat0_q} <= {{crp_pkg::ARCH_HI_W{1'b0}}, array_q[row_q[4:0]]};
      end else if (row_q == crp_pkg::ROW_SIG) begin
        {rdat2_q, rdat1_q, rdat0_q} <= {{crp_pkg::ARCH_HI_W{1'b0}}, sig_q};
      end else if (row_q == crp_pkg::ROW_ARCH) begin
        {rdat2_q, rdat1_q, rdat0_q} <= arch_q;
      end else begin
        {rdat2_q, rdat1_q, rdat0_q} <= {{(crp_pkg::ARCH_BITS - 1){1'b0}}, sec_q};
      end
    end
  end

  // Outcome of the last program or read command
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_q <= 1'b0;
    end else if (prog_go) begin
      err_q <= ~prog_ok;
    end else if (read_go) begin
      err_q <= ~read_ok;
    end
  end

  // ----------------------------------------------------------------------
  // Logic array and macrocells
  // ----------------------------------------------------------------------
  logic [crp_pkg::NUM_CELLS-1:0] q_q;
  logic [crp_pkg::NUM_CELLS-1:0] fb;
  logic [crp_pkg::TERM_BITS-1:0] lits;
  logic [crp_pkg::ARRAY_ROWS-1:0] term;
  crp_pkg::crp_mode_t mode [crp_pkg::NUM_CELLS];
  logic [crp_pkg::NUM_CELLS-1:0] pin_v;
  logic [crp_pkg::NUM_CELLS-1:0] oe_v;
  logic [crp_pkg::NUM_CELLS-1:0] d_v;
  logic [crp_pkg::NUM_CELLS-1:0] chain_d;
  logic chain_top;
  logic syn;
  logic ac0;

  assign syn = arch_q[crp_pkg::ARCH_REGCAP_BIT];
  assign ac0 = arch_q[crp_pkg::ARCH_GLOBAL_BIT];

  function automatic crp_pkg::crp_mode_t decode(logic s, logic a0, logic a1);
    if (s && !a0) begin
      return a1 ? crp_pkg::CM_INPUT : crp_pkg::CM_COMB_ON;
    end else if (s) begin
      return crp_pkg::CM_COMB_PTOE;
    end
    return a1 ? crp_pkg::CM_COMB_PTOE : crp_pkg::CM_REG;
  endfunction

  // Mode and feedback selection per cell
  always_comb begin
    for (int i = 0; i < crp_pkg::NUM_CELLS; i++) begin
      logic sel_a;
      logic sel_b;
      sel_a = ac0;
      sel_b = arch_q[crp_pkg::ARCH_CELL_LSB + i];
      mode[i] = decode(syn, ac0, arch_q[crp_pkg::ARCH_CELL_LSB + i]);
      if (i == crp_pkg::CELL_OUTER_LO || i == crp_pkg::CELL_OUTER_HI) begin
        sel_a = syn;
        sel_b = syn;
      end
      fb[i] = sel_b ? io_s[i] : (sel_a & q_q[i]);
    end
  end

  // True and complement literals, then product terms
  always_comb begin
    lits = '0;
    term = '0;
    for (int k = 0; k < crp_pkg::NUM_IN; k++) begin
      lits[4*k] = in_s[k];
      lits[4*k+1] = ~in_s[k];
      lits[4*k+2] = fb[k];
      lits[4*k+3] = ~fb[k];
    end
    for (int r = 0; r < crp_pkg::ARRAY_ROWS; r++) begin
      term[r] = (|array_q[r]) && ((array_q[r] & ~lits) == '0) && arch_q[crp_pkg::ARCH_PTD_LSB + r];
    end
  end

  // Sum, polarity and enable per cell
  always_comb begin
    for (int i = 0; i < crp_pkg::NUM_CELLS; i++) begin
      logic [crp_pkg::TERMS_PER_CELL-1:0] trm;
      logic sum;
      logic pol;
      trm = term[crp_pkg::TERMS_PER_CELL*i +: crp_pkg::TERMS_PER_CELL];
      pol = arch_q[crp_pkg::ARCH_POL_LSB + i];
      sum = (mode[i] == crp_pkg::CM_COMB_PTOE) ? |trm[crp_pkg::TERMS_PER_CELL-1:1] : |trm;
      pin_v[i] = pol ? sum : ~sum;
      d_v[i] = pol ? ~sum : sum;
      unique case (mode[i])
        crp_pkg::CM_INPUT: oe_v[i] = 1'b0;
        crp_pkg::CM_COMB_ON: oe_v[i] = 1'b1;
        crp_pkg::CM_COMB_PTOE: oe_v[i] = trm[0];
        crp_pkg::CM_REG: oe_v[i] = ~oe_n_s;
      endcase
    end
  end

  // Preload chain skips non-registered cells, bottom cell first
  always_comb begin
    chain_top = sdin_s;
    chain_d = q_q;
    for (int i = 0; i < crp_pkg::NUM_CELLS; i++) begin
      if (mode[i] == crp_pkg::CM_REG) begin
        chain_d[i] = chain_top;
        chain_top = q_q[i];
      end
    end
  end

  // Macrocell registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_q <= '0;
    end else if (!por_done_q) begin
      q_q <= '0;
    end else if (preload_s) begin
      if (shift_edge) begin
        q_q <= chain_d;
      end
    end else begin
      for (int i = 0; i < crp_pkg::NUM_CELLS; i++) begin
        if (mode[i] == crp_pkg::CM_REG) begin
          q_q[i] <= d_v[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered pin drivers
  // ----------------------------------------------------------------------
  logic [crp_pkg::NUM_CELLS-1:0] io_out_q;
  logic [crp_pkg::NUM_CELLS-1:0] io_oe_q;
  logic sdout_oe_q;

  // Registered pins show inverted Q, so cleared registers read high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_out_q <= '0;
      io_oe_q <= '0;
    end else begin
      for (int i = 0; i < crp_pkg::NUM_CELLS; i++) begin
        io_out_q[i] <= (mode[i] == crp_pkg::CM_REG) ? ~q_q[i] : pin_v[i];
      end
      io_oe_q <= oe_v;
    end
  end

  // Open-drain serial out pulls low only in preload
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdout_oe_q <= 1'b0;
    end else begin
      sdout_oe_q <= preload_s & ~chain_top;
    end
  end

  // ----------------------------------------------------------------------
  // Avalon-MM answer
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] readdata_q;
  logic waitrequest_q;

  // Read decode; unmapped addresses answer zero
  always_comb begin
    rd_mux = '0;
    unique case (avs_address)
      crp_pkg::OFS_ROW: rd_mux[crp_pkg::ROW_W-1:0] = row_q;
      crp_pkg::OFS_DATA0: rd_mux = data0_q;
      crp_pkg::OFS_DATA1: rd_mux = data1_q;
      crp_pkg::OFS_DATA2: rd_mux[crp_pkg::ARCH_HI_W-1:0] = data2_q;
      crp_pkg::OFS_RDAT0: rd_mux = rdat0_q;
      crp_pkg::OFS_RDAT1: rd_mux = rdat1_q;
      crp_pkg::OFS_RDAT2: rd_mux[crp_pkg::ARCH_HI_W-1:0] = rdat2_q;
      crp_pkg::OFS_STATUS: begin
        rd_mux[crp_pkg::STAT_SEC_BIT] = sec_q;
        rd_mux[crp_pkg::STAT_ERR_BIT] = err_q;
        rd_mux[crp_pkg::STAT_PRELOAD_BIT] = preload_s;
        rd_mux[crp_pkg::STAT_POR_BIT] = por_done_q;
      end
      default: rd_mux = '0;
    endcase
  end

  // Waitrequest drops for one cycle per taken request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitrequest_q <= 1'b1;
      readdata_q <= '0;
    end else begin
      waitrequest_q <= ~take;
      if (rd) begin
        readdata_q <= rd_mux;
      end
    end
  end

  assign avs_readdata = readdata_q;
  assign avs_waitrequest = waitrequest_q;
  assign io_out = io_out_q;
  assign io_oe = io_oe_q;
  assign sdout_out = 1'b0;
  assign sdout_oe = sdout_oe_q;
  assign por_done = por_done_q;

endmodule // crp_top

// ==== crp_pkg.sv ====
// Constants and types shared by the configuration-row and preload block.
// Assumes a single 20 MHz clock domain and a 32-bit Avalon-MM register slave.

package crp_pkg;

  // ----------------------------------------------------------------------
  // Clock and power-up timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned POR_TIME_NS = 45_000;
  // Longest time, so rounded down to whole cycles
  localparam int unsigned POR_CYC = (POR_TIME_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int unsigned POR_CNT_W = $clog2(POR_CYC + 1);
  localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYC - 1);

  // ----------------------------------------------------------------------
  // Memory organisation
  // ----------------------------------------------------------------------
  localparam int unsigned ROW_W = 6;
  localparam int unsigned USER_ROW_COUNT = 36;
  localparam int unsigned ARRAY_ROWS = 32;
  localparam int unsigned TERM_BITS = 64;
  localparam int unsigned SIG_BITS = 64;
  localparam int unsigned ARCH_BITS = 82;
  localparam int unsigned ARCH_HI_W = ARCH_BITS - 64;
  localparam int unsigned NUM_CELLS = 8;
  localparam int unsigned NUM_IN = 8;
  localparam int unsigned TERMS_PER_CELL = ARRAY_ROWS / NUM_CELLS;

  localparam logic [ROW_W-1:0] ROW_ARRAY_LAST = 6'h1f;
  localparam logic [ROW_W-1:0] ROW_SIG = 6'h20;
  localparam logic [ROW_W-1:0] ROW_RSV_FIRST = 6'h21;
  localparam logic [ROW_W-1:0] ROW_RSV_LAST = 6'h3b;
  localparam logic [ROW_W-1:0] ROW_ARCH = 6'h3c;
  localparam logic [ROW_W-1:0] ROW_SEC = 6'h3d;
  localparam logic [ROW_W-1:0] ROW_ERASE = 6'h3f;

  // Architecture word layout
  localparam int unsigned ARCH_POL_LSB = 0;
  localparam int unsigned ARCH_CELL_LSB = 8;
  localparam int unsigned ARCH_GLOBAL_BIT = 16;
  localparam int unsigned ARCH_REGCAP_BIT = 17;
  localparam int unsigned ARCH_PTD_LSB = 18;
  localparam int unsigned CELL_OUTER_LO = 0;
  localparam int unsigned CELL_OUTER_HI = 7;

  // Erased (virgin) contents
  localparam logic [TERM_BITS-1:0] ROW_ERASED = 64'h0;
  localparam logic [SIG_BITS-1:0] SIG_ERASED = 64'h0;
  localparam logic [ARCH_BITS-1:0] ARCH_ERASED = {ARCH_BITS{1'b1}};

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFS_ROW = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_DATA0 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA1 = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA2 = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_CMD = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_RDAT0 = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_RDAT1 = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_RDAT2 = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h20;

  localparam int unsigned CMD_PROG_BIT = 0;
  localparam int unsigned CMD_READ_BIT = 1;
  localparam int unsigned STAT_SEC_BIT = 0;
  localparam int unsigned STAT_ERR_BIT = 1;
  localparam int unsigned STAT_PRELOAD_BIT = 2;
  localparam int unsigned STAT_POR_BIT = 3;

  // Macrocell configuration, Gray coded
  typedef enum logic [1:0] {
    CM_INPUT = 2'b00,
    CM_COMB_ON = 2'b01,
    CM_COMB_PTOE = 2'b11,
    CM_REG = 2'b10
  } crp_mode_t;

endpackage

// ==== crp_sync2.sv ====
// Two-stage synchroniser for a vector of independent pin levels.
// Assumes each bit is a slow level; no bus coherence between bits.

module crp_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // crp_sync2

// ==== crp_top_monitor.sv ====
// Checker of the bus handshake, power-up window and preload pins.
// Assumes it is bound to crp_top and sees only its ports.
module crp_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Preload and status
  input wire logic preload_entry_pin,
  input wire logic preload_shift_clock,
  input wire logic sdout_out,
  input wire logic sdout_oe,
  input wire logic por_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] cyc_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Edges since reset release, saturating
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cyc_q <= 10'h0;
    else if (cyc_q != 10'h3ff) cyc_q <= cyc_q + 10'h1;
  end
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  por_time_a: assert property ($rose(por_done) |-> cyc_q == 10'h384)
    else $error("power-up window length wrong");
  por_stay_a: assert property (por_done |=> por_done)
    else $error("power-up flag dropped");
  sdout_drive_a: assert property (!sdout_out)
    else $error("serial out drives high");
  sdout_idle_a: assert property (!preload_entry_pin [*6] |-> !sdout_oe)
    else $error("serial out active outside preload");
  shift_hold_a: assert property ((preload_entry_pin && $stable(preload_shift_clock)) [*8] |-> $stable(sdout_oe))
    else $error("chain moved without shift");
  cover property ($rose(por_done));
  cover property (avs_write && !avs_waitrequest);
  cover property ($rose(sdout_oe));
endmodule // crp_monitor

bind crp_top crp_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .preload_entry_pin(preload_entry_pin),
  .preload_shift_clock(preload_shift_clock), .sdout_out(sdout_out), .sdout_oe(sdout_oe), .por_done(por_done));

// ==== crp_tester.sv ====
// Test equipment model driving the preload entry, shift clock and serial data.
// Assumes the bench calls its tasks; all pins change just after clk rises.
module crp_tester (
  // Clock
  input wire logic clk,
  // Test pins
  output logic entry,
  output logic sclk,
  output logic sdin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins idle at power-up, shift clock stands still
  initial begin
    entry = 1'b0;
    sclk = 1'b0;
    sdin = 1'b0;
  end
  // Raise entry pin to the test level
  task automatic enter();
    @(posedge clk);
    entry <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // Drop entry pin back to normal level
  task automatic leave();
    @(posedge clk);
    entry <= 1'b0;
  endtask
  // One bit per shift clock rise, data held around the rise
  task automatic shift(input logic b);
    @(posedge clk);
    sdin <= b;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    sclk <= 1'b0;
    repeat (3) @(posedge clk);
    sdin <= ~b; // Hold over, line no longer meaningful
  endtask
endmodule // crp_tester

// ==== crp_top_tb.sv ====
// Bench for row map, security, erase, macrocell decode, preload and power-up.
// Assumes crp_pkg, crp_top, crp_tester and the bound monitor are compiled first.
module crp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, oe_n_pin, sdout_out, sdout_oe, por_done;
  logic entry, sclk, sdin;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, r0, r1, r2, st;
  logic [7:0] io_in, io_out, io_oe;
  int error_cnt, n_compared, acc;
  assign io_in = io_out & io_oe; // Undriven pins read low
  crp_top i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_pin(8'h00), .oe_n_pin(oe_n_pin), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .preload_entry_pin(entry), .preload_shift_clock(sclk), .sdin_pin(sdin),
    .sdout_out(sdout_out), .sdout_oe(sdout_oe), .por_done(por_done));
  crp_tester i_tst (.clk(clk), .entry(entry), .sclk(sclk), .sdin(sdin));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Verdict and end of run
  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      chk("bus_timeout", {31'h0, avs_waitrequest}, 32'h0);
      wrap_up();
    end
  endtask
  // Program one row, then fetch status
  task automatic prog(input logic [5:0] row, input logic [31:0] d0, input logic [31:0] d1);
    logic [31:0] q;
    bus(1'b1, crp_pkg::OFS_ROW, {26'h0, row}, q);
    bus(1'b1, crp_pkg::OFS_DATA0, d0, q);
    bus(1'b1, crp_pkg::OFS_DATA1, d1, q);
    bus(1'b1, crp_pkg::OFS_DATA2, 32'h0, q);
    bus(1'b1, crp_pkg::OFS_CMD, 32'h1, q);
    bus(1'b0, crp_pkg::OFS_STATUS, 32'h0, st);
  endtask
  // Read one row back
  task automatic rd(input logic [5:0] row);
    logic [31:0] q;
    bus(1'b1, crp_pkg::OFS_ROW, {26'h0, row}, q);
    bus(1'b1, crp_pkg::OFS_CMD, 32'h2, q);
    bus(1'b0, crp_pkg::OFS_RDAT0, 32'h0, r0);
    bus(1'b0, crp_pkg::OFS_RDAT1, 32'h0, r1);
    bus(1'b0, crp_pkg::OFS_RDAT2, 32'h0, r2);
  endtask
  // Main sequence
  initial begin
    error_cnt = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h0;
    avs_writedata = 32'h0;
    oe_n_pin = 1'b1;
    repeat (10) @(posedge clk);
    chk("reset_outputs", {22'h0, avs_waitrequest, por_done, io_oe}, 32'h200);
    sys_rst <= 1'b0;
    acc = 0;
    for (int r = 0; r < 64; r++) begin
      prog(r[5:0], 32'h0, 32'h0);
      if (st[1] === 1'b0) acc++;
    end
    chk("rows_accepted", acc, 32'h24);
    rd(crp_pkg::ROW_ARCH);
    chk("arch_erased", r2, 32'h3ffff);
    chk("arch_erased_lo", r0, 32'hffffffff);
    prog(crp_pkg::ROW_SIG, 32'h5a5a0f0f, 32'hc3c33c3c);
    prog(6'h05, 32'h11, 32'h80000000);
    rd(6'h05);
    chk("array_row", r0, 32'h11);
    chk("array_row_hi", r1, 32'h80000000);
    prog(crp_pkg::ROW_SEC, 32'h0, 32'h0);
    chk("secure_set", st & 32'h3, 32'h1);
    prog(6'h05, 32'hffff, 32'h0);
    chk("prog_blocked", st & 32'h3, 32'h3);
    rd(6'h05);
    chk("read_blocked", r0, 32'h0);
    rd(crp_pkg::ROW_SIG);
    chk("sig_secure", r0, 32'h5a5a0f0f);
    chk("sig_secure_hi", r1, 32'hc3c33c3c);
    prog(crp_pkg::ROW_ERASE, 32'h0, 32'h0);
    chk("erase_status", st & 32'h3, 32'h0);
    rd(crp_pkg::ROW_SIG);
    chk("sig_erased", r0 | r1, 32'h0);
    rd(6'h05);
    chk("row_erased", r0 | r1, 32'h0);
    oe_n_pin <= 1'b0;
    prog(crp_pkg::ROW_ARCH, 32'h0002000f, 32'h0);
    repeat (4) @(posedge clk);
    chk("polarity", {16'h0, io_oe, io_out}, 32'hfff0);
    // Fresh device: registered pins stay high until the power-up window ends
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    prog(crp_pkg::ROW_ARCH, 32'h0001f8ff, 32'h0);
    chk("reg_pins", {15'h0, por_done, io_oe, io_out}, 32'h0707);
    for (int i = 0; i < 1000 && por_done !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("por_done", {31'h0, por_done}, 32'h1);
    if (por_done !== 1'b1) wrap_up();
    chk("capture_high", {16'h0, io_oe, io_out}, 32'h0700);
    prog(crp_pkg::ROW_ARCH, 32'h0001f8f8, 32'h0);
    chk("capture_low", {16'h0, io_oe, io_out}, 32'h0707);
    i_tst.enter();
    i_tst.shift(1'b1);
    repeat (2) @(posedge clk);
    chk("sdout_first", {31'h0, sdout_oe}, 32'h1);
    i_tst.shift(1'b0);
    i_tst.shift(1'b1);
    repeat (2) @(posedge clk);
    chk("preload_pins", {24'h0, io_out}, 32'h02);
    chk("sdout_last", {31'h0, sdout_oe}, 32'h0);
    i_tst.leave();
    repeat (8) @(posedge clk);
    chk("normal_capture", {24'h0, io_out}, 32'h07);
    wrap_up();
  end
endmodule // crp_top_tb
